// ===== rtl/i2cm_top.v
`include "i2cm_defs.vh"

module i2cm_top #(
  parameter DATA_W = 8,
  parameter [15:0] LOW_CYC = `I2CM_LOW_CYC,
  parameter [15:0] HIGH_CYC = `I2CM_HIGH_CYC,
  parameter [15:0] SU_CYC = `I2CM_SU_CYC,
  parameter [15:0] FREE_CYC = `I2CM_FREE_CYC
) (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_scl,
  output wire o_scl,
  output wire o_scl_oe,
  input wire i_sda,
  output wire o_sda,
  output wire o_sda_oe,
  input wire [2:0] i_mode,
  input wire i_addr_buffer_disable,
  input wire i_restart_enable,
  input wire i_start_set,
  input wire [7:0] i_addr_high_buffer,
  input wire [7:0] i_addr_low_buffer,
  input wire i_tx_write,
  input wire [7:0] i_transmit_buffer,
  input wire i_cnt_load,
  input wire [7:0] i_cnt_value,
  input wire i_ack_data_value,
  input wire i_end_of_count_ack,
  input wire i_address_hold_enable,
  input wire i_stretch_disable,
  input wire [6:0] i_own_addr,
  input wire i_stretch_clear,
  input wire i_start_irq_enable,
  input wire i_restart_irq_enable,
  input wire i_receive_irq_enable,
  input wire i_nack_irq_enable,
  input wire i_collision_irq_enable,
  input wire [10:0] i_flag_clear,
  input wire i_rx_ready,
  output wire o_rx_valid,
  output wire [DATA_W-1:0] o_receive_buffer,
  output wire o_rx_buffer_full,
  output wire o_tx_buffer_empty,
  output wire [7:0] o_byte_counter,
  output wire o_master_pause_flag,
  output wire o_master_active_flag,
  output wire o_bus_free_flag,
  output wire o_slave_active_flag,
  output wire o_slave_stretch_bit,
  output wire o_start_detect_flag,
  output wire o_restart_detect_flag,
  output wire o_stop_detect_flag,
  output wire o_nack_detect_flag,
  output wire o_count_done_flag,
  output wire o_transmit_flag,
  output wire o_receive_flag,
  output wire o_collision_flag,
  output wire o_address_match_flag,
  output wire o_general_irq_flag,
  output wire o_error_irq_flag
);

  localparam [9:0] S_IDLE = 10'h001;
  localparam [9:0] S_START = 10'h002;
  localparam [9:0] S_LOAD = 10'h004;
  localparam [9:0] S_LOW = 10'h008;
  localparam [9:0] S_RISE = 10'h010;
  localparam [9:0] S_HIGH = 10'h020;
  localparam [9:0] S_PAUSE = 10'h040;
  localparam [9:0] S_RESTART = 10'h080;
  localparam [9:0] S_STOP = 10'h100;
  localparam [9:0] S_SLV = 10'h200;

  // ----------------------------------------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------------------------------------
  reg scl_m_ff, scl_s_ff, scl_d_ff;
  reg sda_m_ff, sda_s_ff, sda_d_ff;
  reg bfree_ff;
  reg [15:0] idle_cnt_ff;
  wire scl_rise = scl_s_ff & ~scl_d_ff;
  wire scl_fall = ~scl_s_ff & scl_d_ff;
  wire bus_start = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
  wire bus_stop = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      bfree_ff <= 1'b0;
      idle_cnt_ff <= 16'h0000;
    end else begin
      scl_m_ff <= i_scl;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= i_sda;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
      // Free only after a Stop or a long quiet spell with both lines high
      if (bus_start) begin
        bfree_ff <= 1'b0; // [RULE_16]
      end else if (bus_stop) begin
        bfree_ff <= 1'b1; // [RULE_16]
      end else if (scl_s_ff & sda_s_ff) begin
        if (idle_cnt_ff >= FREE_CYC - 16'h0001) begin
          bfree_ff <= 1'b1;
        end else begin
          idle_cnt_ff <= idle_cnt_ff + 16'h0001;
        end
      end else begin
        idle_cnt_ff <= 16'h0000;
        bfree_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Master and slave sequencer
  // ----------------------------------------------------------------------
  reg [9:0] st_ff;
  reg [1:0] sub_ff, kind_ff, why_ff;
  reg [15:0] cnt_ff;
  reg [8:0] sh_ff;
  reg [7:0] rxsh_ff, txb_ff, bcnt_ff, pdat_ff;
  reg [3:0] idx_ff;
  reg scl_oe_ff, sda_oe_ff, mdr_ff, mact_ff, sact_ff, slave_stretch_bit_ff;
  reg txe_ff, req_ff, rw_ff, rd_rst_ff, push_ff, pin_lo_ff;
  reg [`I2CM_NF-1:0] set_ff, flag_ff;
  reg full_ff;

  wire t_low = cnt_ff >= LOW_CYC - 16'h0001;
  wire t_high = cnt_ff >= HIGH_CYC - 16'h0001;
  wire t_su = cnt_ff >= SU_CYC - 16'h0001;
  wire abd = i_addr_buffer_disable;
  wire mm = i_mode[2:1] == `I2CM_MODE_MM;
  wire master_ok = mm | (i_mode == `I2CM_MODE_M10); // [RULE_23]
  wire is_rx = kind_ff == `I2CM_K_RX;
  // Read bits and the slave's ack slot are listened to, never arbitrated
  wire chk = is_rx ? (idx_ff == 4'h8) : (idx_ff != 4'h8);
  wire [7:0] rx_byte = {rxsh_ff[6:0], sda_s_ff};
  wire ld_tx = abd ? ~is_rx : (kind_ff == `I2CM_K_TX);
  reg [7:0] ld_byte;

  always @* begin
    case (kind_ff)
      `I2CM_K_AH: ld_byte = abd ? txb_ff : {i_addr_high_buffer[7:1], rd_rst_ff};
      `I2CM_K_AL: ld_byte = abd ? txb_ff : i_addr_low_buffer;
      `I2CM_K_TX: ld_byte = txb_ff;
      default: ld_byte = 8'hff;
    endcase
  end

  task go_pause(input [1:0] why);
    begin
      st_ff <= S_PAUSE;
      why_ff <= why;
      mdr_ff <= 1'b1;
      scl_oe_ff <= 1'b1;
      sda_oe_ff <= 1'b0;
    end
  endtask

  // Restart enable trades the Stop for a held pause
  task go_end;
    begin
      cnt_ff <= 16'h0000;
      sub_ff <= 2'h0;
      if (i_restart_enable) begin
        go_pause(`I2CM_P_RST); // [RULE_24]
      end else begin
        st_ff <= S_STOP; // [RULE_01]
      end
    end
  endtask

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_ff <= S_IDLE;
      sub_ff <= 2'h0;
      kind_ff <= `I2CM_K_AH;
      why_ff <= `I2CM_P_DATA;
      cnt_ff <= 16'h0000;
      sh_ff <= 9'h1ff;
      rxsh_ff <= 8'h00;
      txb_ff <= 8'h00;
      bcnt_ff <= 8'h00;
      pdat_ff <= 8'h00;
      idx_ff <= 4'h0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      mdr_ff <= 1'b0;
      mact_ff <= 1'b0;
      sact_ff <= 1'b0;
      slave_stretch_bit_ff <= 1'b0;
      txe_ff <= 1'b1;
      req_ff <= 1'b0;
      rw_ff <= 1'b0;
      rd_rst_ff <= 1'b0;
      push_ff <= 1'b0;
      pin_lo_ff <= 1'b0;
      set_ff <= {`I2CM_NF{1'b0}};
    end else begin
      set_ff <= {`I2CM_NF{1'b0}};
      set_ff[`I2CM_F_STOP] <= bus_stop; // [RULE_01]
      push_ff <= 1'b0;
      pin_lo_ff <= 1'b0;
      cnt_ff <= cnt_ff + 16'h0001;
      if (i_stretch_clear) begin
        slave_stretch_bit_ff <= 1'b0; // [RULE_18]
      end
      if (bus_stop) begin
        sact_ff <= 1'b0;
      end
      if (st_ff == S_IDLE && !mact_ff) begin
        if (abd ? i_tx_write : i_start_set) begin
          req_ff <= 1'b1; // [RULE_02] [RULE_03]
        end
      end
      case (st_ff)
        S_IDLE: begin
          scl_oe_ff <= 1'b0;
          sda_oe_ff <= 1'b0;
          mdr_ff <= 1'b0;
          if (bus_start && mm) begin
            st_ff <= S_SLV;
            sub_ff <= 2'h0;
            idx_ff <= 4'h0;
          end else if (req_ff && bfree_ff && !sact_ff && !flag_ff[`I2CM_F_COLL] && master_ok) begin
            st_ff <= S_START; // [RULE_16] [RULE_19] [RULE_22]
            sda_oe_ff <= 1'b1;
            cnt_ff <= 16'h0000;
            rd_rst_ff <= 1'b0;
          end
        end
        S_START: begin
          if (t_su) begin
            scl_oe_ff <= 1'b1;
            mact_ff <= 1'b1; // [RULE_04]
            set_ff[`I2CM_F_START] <= 1'b1; // [RULE_04]
            req_ff <= 1'b0;
            kind_ff <= `I2CM_K_AH;
            st_ff <= S_LOAD;
          end
        end
        S_LOAD: begin
          cnt_ff <= 16'h0000;
          idx_ff <= 4'h0;
          if (kind_ff == `I2CM_K_TX && bcnt_ff == 8'h00) begin
            set_ff[`I2CM_F_CNT] <= 1'b1; // [RULE_01]
            go_end;
          end else if (ld_tx && txe_ff) begin
            if (kind_ff == `I2CM_K_TX) begin
              set_ff[`I2CM_F_TX] <= 1'b1;
            end
            go_pause(`I2CM_P_DATA);
          end else begin
            sh_ff <= {ld_byte, 1'b1};
            sda_oe_ff <= ~ld_byte[7];
            if (ld_tx) begin
              txe_ff <= 1'b1;
            end
            if (kind_ff == `I2CM_K_AH) begin
              rw_ff <= ld_byte[0];
            end
            st_ff <= S_LOW;
          end
        end
        S_LOW: begin
          scl_oe_ff <= 1'b1;
          if (t_low) begin
            scl_oe_ff <= 1'b0;
            st_ff <= S_RISE;
          end
        end
        S_RISE: begin
          cnt_ff <= 16'h0000;
          if (scl_s_ff) begin
            st_ff <= S_HIGH; // [RULE_05] [RULE_20]
          end
        end
        S_HIGH: begin
          // Compare against the level actually driven, so our own ack never collides
          if (chk && !sda_oe_ff && !sda_s_ff) begin
            set_ff[`I2CM_F_COLL] <= 1'b1; // [RULE_21]
            scl_oe_ff <= 1'b0; // [RULE_22]
            sda_oe_ff <= 1'b0;
            mact_ff <= 1'b0;
            rxsh_ff <= rx_byte;
            idx_ff <= idx_ff + 4'h1;
            sub_ff <= 2'h0;
            if (mm && !is_rx && kind_ff != `I2CM_K_TX && idx_ff != 4'h8) begin
              st_ff <= S_SLV; // [RULE_22]
            end else begin
              st_ff <= S_IDLE;
            end
          end else if (t_high || scl_fall) begin
            // Another master pulling low ends our high early
            rxsh_ff <= rx_byte; // [RULE_11] [RULE_20]
            scl_oe_ff <= 1'b1;
            cnt_ff <= 16'h0000;
            st_ff <= S_LOW;
            if (idx_ff == 4'h8) begin
              sda_oe_ff <= 1'b0;
              if (kind_ff == `I2CM_K_RX) begin
                if (bcnt_ff != 8'h00) begin
                  st_ff <= S_LOAD;
                end else if (sda_s_ff) begin
                  go_end; // [RULE_15]
                end else begin
                  go_pause(`I2CM_P_RST); // [RULE_15]
                end
              end else if (sda_s_ff) begin
                set_ff[`I2CM_F_NACK] <= 1'b1; // [RULE_06] [RULE_08]
                go_end; // [RULE_08]
              end else if (kind_ff == `I2CM_K_AH) begin
                kind_ff <= rw_ff ? `I2CM_K_RX : `I2CM_K_AL; // [RULE_06] [RULE_11]
                st_ff <= S_LOAD;
              end else if (kind_ff == `I2CM_K_AL && i_restart_enable) begin
                go_pause(`I2CM_P_RST); // [RULE_07]
              end else begin
                if (kind_ff == `I2CM_K_TX) begin
                  bcnt_ff <= bcnt_ff - 8'h01;
                end
                kind_ff <= `I2CM_K_TX;
                st_ff <= S_LOAD;
              end
            end else begin
              idx_ff <= idx_ff + 4'h1;
              sh_ff <= {sh_ff[7:0], 1'b1};
              sda_oe_ff <= ~sh_ff[7];
              if (is_rx && idx_ff == 4'h7) begin
                push_ff <= 1'b1; // [RULE_13]
                pdat_ff <= rx_byte;
                set_ff[`I2CM_F_RX] <= 1'b1; // [RULE_13]
                if (bcnt_ff != 8'h00) begin
                  bcnt_ff <= bcnt_ff - 8'h01; // [RULE_13]
                end
                if (bcnt_ff <= 8'h01) begin
                  sda_oe_ff <= ~i_end_of_count_ack; // [RULE_14]
                  set_ff[`I2CM_F_CNT] <= 1'b1; // [RULE_14]
                end else begin
                  sda_oe_ff <= ~i_ack_data_value; // [RULE_14]
                end
              end
              if (is_rx && idx_ff == 4'h6 && full_ff) begin
                go_pause(`I2CM_P_RX); // [RULE_12]
              end
            end
          end
        end
        S_PAUSE: begin
          scl_oe_ff <= 1'b1;
          cnt_ff <= 16'h0000;
          sub_ff <= 2'h0;
          if (why_ff == `I2CM_P_DATA && !txe_ff) begin
            mdr_ff <= 1'b0;
            st_ff <= S_LOAD;
          end else if (why_ff == `I2CM_P_RX && !full_ff) begin
            mdr_ff <= 1'b0; // [RULE_12]
            st_ff <= S_LOW;
          end else if (why_ff == `I2CM_P_RST && (abd ? !txe_ff : i_start_set)) begin
            mdr_ff <= 1'b0; // [RULE_07] [RULE_08]
            rd_rst_ff <= 1'b1;
            st_ff <= S_RESTART;
          end
        end
        S_RESTART: begin
          if (sub_ff == 2'h0) begin
            if (t_low) begin
              scl_oe_ff <= 1'b0;
              sub_ff <= 2'h1;
            end
          end else if (sub_ff == 2'h1) begin
            if (!scl_s_ff) begin
              cnt_ff <= 16'h0000;
            end else if (t_su) begin
              sda_oe_ff <= 1'b1;
              cnt_ff <= 16'h0000;
              sub_ff <= 2'h2;
            end
          end else if (t_su) begin
            scl_oe_ff <= 1'b1;
            set_ff[`I2CM_F_RESTART] <= 1'b1; // [RULE_10]
            kind_ff <= `I2CM_K_AH; // [RULE_10]
            st_ff <= S_LOAD;
          end
        end
        S_STOP: begin
          if (sub_ff == 2'h0) begin
            scl_oe_ff <= 1'b1;
            sda_oe_ff <= 1'b1;
            if (t_low) begin
              scl_oe_ff <= 1'b0;
              sub_ff <= 2'h1;
            end
          end else if (sub_ff == 2'h1) begin
            if (!scl_s_ff) begin
              cnt_ff <= 16'h0000;
            end else if (t_su) begin
              sda_oe_ff <= 1'b0;
              cnt_ff <= 16'h0000;
              sub_ff <= 2'h2;
            end
          end else if (t_su) begin
            mact_ff <= 1'b0;
            st_ff <= S_IDLE;
          end
        end
        default: begin
          // Listening as a slave: count bits, then answer own address
          if (bus_stop) begin
            st_ff <= S_IDLE;
          end else if (sub_ff == 2'h0) begin
            if (scl_rise) begin
              rxsh_ff <= rx_byte;
              idx_ff <= idx_ff + 4'h1;
            end else if (scl_fall && idx_ff == 4'h8) begin
              if (rxsh_ff[7:1] == i_own_addr && i_address_hold_enable && !i_stretch_disable) begin
                sact_ff <= 1'b1; // [RULE_18]
                slave_stretch_bit_ff <= 1'b1; // [RULE_18]
                set_ff[`I2CM_F_ADDR] <= 1'b1; // [RULE_18]
                scl_oe_ff <= 1'b1;
                sda_oe_ff <= 1'b1;
                sub_ff <= 2'h1;
              end else begin
                st_ff <= S_IDLE;
              end
            end
          end else if (sub_ff == 2'h1) begin
            if (!slave_stretch_bit_ff) begin
              scl_oe_ff <= 1'b0;
              sub_ff <= 2'h2;
            end
          end else if (scl_fall) begin
            sda_oe_ff <= 1'b0;
            st_ff <= S_IDLE;
          end
        end
      endcase
      // Software load beats the hardware decrement
      if (i_cnt_load) begin
        bcnt_ff <= i_cnt_value;
      end
      // A write in the same cycle as a take leaves the buffer full
      if (i_tx_write) begin
        txb_ff <= i_transmit_buffer;
        txe_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sticky flags: a set in the clearing cycle wins
  // ----------------------------------------------------------------------
  wire girq = (set_ff[`I2CM_F_START] & i_start_irq_enable) |
              (set_ff[`I2CM_F_RESTART] & i_restart_irq_enable) |
              (set_ff[`I2CM_F_RX] & i_receive_irq_enable);
  wire eirq = (set_ff[`I2CM_F_NACK] & i_nack_irq_enable) |
              (set_ff[`I2CM_F_COLL] & i_collision_irq_enable);

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      flag_ff <= {`I2CM_NF{1'b0}};
    end else begin
      flag_ff <= (flag_ff & ~i_flag_clear) | set_ff | {eirq, girq, 9'h000}; // [RULE_04] [RULE_08]
    end
  end

  // ----------------------------------------------------------------------
  // Two-entry receive buffer
  // ----------------------------------------------------------------------
  reg [DATA_W-1:0] head_ff, tail_ff;
  reg hv_ff, tv_ff;
  reg nxt_hv, nxt_tv;
  wire pop = hv_ff & i_rx_ready;

  always @* begin
    nxt_hv = hv_ff;
    nxt_tv = tv_ff;
    if (pop) begin
      nxt_hv = tv_ff;
      nxt_tv = 1'b0;
    end
    if (push_ff) begin
      if (!nxt_hv) begin
        nxt_hv = 1'b1;
      end else begin
        nxt_tv = 1'b1;
      end
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      head_ff <= {DATA_W{1'b0}};
      tail_ff <= {DATA_W{1'b0}};
      hv_ff <= 1'b0;
      tv_ff <= 1'b0;
      full_ff <= 1'b0;
    end else begin
      hv_ff <= nxt_hv;
      tv_ff <= nxt_tv;
      full_ff <= nxt_hv & nxt_tv;
      if (pop && tv_ff) begin
        head_ff <= tail_ff;
      end
      if (push_ff) begin
        if (!hv_ff || (pop && !tv_ff)) begin
          head_ff <= pdat_ff[DATA_W-1:0];
        end else begin
          tail_ff <= pdat_ff[DATA_W-1:0];
        end
      end
    end
  end

  assign o_scl = pin_lo_ff;
  assign o_sda = pin_lo_ff;
  assign o_scl_oe = scl_oe_ff;
  assign o_sda_oe = sda_oe_ff;
  assign o_rx_valid = hv_ff;
  assign o_receive_buffer = head_ff;
  assign o_rx_buffer_full = full_ff;
  assign o_tx_buffer_empty = txe_ff;
  assign o_byte_counter = bcnt_ff;
  assign o_master_pause_flag = mdr_ff;
  assign o_master_active_flag = mact_ff;
  assign o_bus_free_flag = bfree_ff;
  assign o_slave_active_flag = sact_ff;
  assign o_slave_stretch_bit = slave_stretch_bit_ff;
  assign o_start_detect_flag = flag_ff[`I2CM_F_START];
  assign o_restart_detect_flag = flag_ff[`I2CM_F_RESTART];
  assign o_stop_detect_flag = flag_ff[`I2CM_F_STOP];
  assign o_nack_detect_flag = flag_ff[`I2CM_F_NACK];
  assign o_count_done_flag = flag_ff[`I2CM_F_CNT];
  assign o_transmit_flag = flag_ff[`I2CM_F_TX];
  assign o_receive_flag = flag_ff[`I2CM_F_RX];
  assign o_collision_flag = flag_ff[`I2CM_F_COLL];
  assign o_address_match_flag = flag_ff[`I2CM_F_ADDR];
  assign o_general_irq_flag = flag_ff[`I2CM_F_GIRQ];
  assign o_error_irq_flag = flag_ff[`I2CM_F_EIRQ];

endmodule

// ===== rtl/i2cm_defs.vh
`ifndef I2CM_DEFS_VH
`define I2CM_DEFS_VH
// Notes on behaviour
// RULE_01: Transmit, buffer empty and count zero: no transmit flag, count done, Stop.
// RULE_02: Buffers on: high/low address bytes, restart enable, start; waits for bus free.
// RULE_03: Buffers off: transmit write starts automatically on idle bus; start writes ignored.
// RULE_04: After Start: master active, start flag, general interrupt if enabled.
// RULE_05: After an address byte, wait for SCL high before the ninth clock.
// RULE_06: High address NACK sets NACK flag and ends; ACK sends low address byte.
// RULE_07: Low address ACK in read setup: pause, hold SCL, wait for start.
// RULE_08: Address NACK: NACK flag, Stop or pause with restart; error interrupt if enabled.
// RULE_09: Software loads receive count, then start or read address write.
// RULE_10: Restart sets restart flag, general interrupt if enabled, then high address with read.
// RULE_11: After read address ACK, first seven data bits shift into receiver.
// RULE_12: Receive buffer full at seven bits: pause, hold SCL low until read.
// RULE_13: Eighth bit: byte to buffer, receive flag, interrupt if enabled, count minus one.
// RULE_14: Count non-zero drives ack data; zero drives end-of-count ack, count done.
// RULE_15: Stop follows only a NACK seen on the bus; otherwise bus stalls.
// RULE_16: Bus free flag only when bus idle; master starts only while it is set.
// RULE_17: Multi-master: software sets address hold enable, clears stretch disable.
// RULE_18: Matching address: slave active, address flag, stretch bit, SCL held until cleared.
// RULE_19: Slave activity has priority; no master start while slave active.
// RULE_20: Clock synchronisation: low timed after SCL low, high timed after release.
// RULE_21: High period SDA low while sending high: collision flag, error interrupt if enabled.
// RULE_22: Collision releases lines; in addressing go slave checking; clear flag to resume.
// RULE_23: Mode 101 is master 10-bit; 110 and 111 are multi-master.
// RULE_24: With restart enable, pause on ninth fall instead of Stop.
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define I2CM_CLK_MHZ 200
`define I2CM_T_LOW_NS 4700
`define I2CM_T_HIGH_NS 4000
`define I2CM_T_SU_NS 4700
`define I2CM_T_FREE_NS 4700
`define I2CM_LOW_CYC ((`I2CM_T_LOW_NS * `I2CM_CLK_MHZ + 999) / 1000)
`define I2CM_HIGH_CYC ((`I2CM_T_HIGH_NS * `I2CM_CLK_MHZ) / 1000)
`define I2CM_SU_CYC ((`I2CM_T_SU_NS * `I2CM_CLK_MHZ + 999) / 1000)
`define I2CM_FREE_CYC ((`I2CM_T_FREE_NS * `I2CM_CLK_MHZ + 999) / 1000)
// ----------------------------------------------------------------------
// Modes, byte kinds, pause reasons, flag positions
// ----------------------------------------------------------------------
`define I2CM_MODE_M10 3'h5
`define I2CM_MODE_MM 2'h3
`define I2CM_K_AH 2'h0
`define I2CM_K_AL 2'h1
`define I2CM_K_TX 2'h2
`define I2CM_K_RX 2'h3
`define I2CM_P_DATA 2'h0
`define I2CM_P_RX 2'h1
`define I2CM_P_RST 2'h2
`define I2CM_NF 11
`define I2CM_F_START 0
`define I2CM_F_RESTART 1
`define I2CM_F_STOP 2
`define I2CM_F_NACK 3
`define I2CM_F_CNT 4
`define I2CM_F_TX 5
`define I2CM_F_RX 6
`define I2CM_F_COLL 7
`define I2CM_F_ADDR 8
`define I2CM_F_GIRQ 9
`define I2CM_F_EIRQ 10
`endif

// ===== tb/i2cm_monitor.sv
module i2cm_monitor (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_nack_irq_enable,
  input wire o_scl_oe,
  input wire o_sda_oe,
  input wire o_rx_valid,
  input wire [7:0] o_byte_counter,
  input wire o_master_pause_flag,
  input wire o_master_active_flag,
  input wire o_bus_free_flag,
  input wire o_slave_active_flag,
  input wire o_start_detect_flag,
  input wire o_nack_detect_flag,
  input wire o_count_done_flag,
  input wire o_receive_flag,
  input wire o_error_irq_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  sequence s_launch;
    $rose(o_sda_oe) && !o_master_active_flag && !o_scl_oe;
  endsequence
  free_start_a: assert property (s_launch |-> $past(o_bus_free_flag))
    else $error("start on busy bus");
  slave_first_a: assert property (s_launch |-> !$past(o_slave_active_flag))
    else $error("start while slave active");
  free_idle_a: assert property (o_bus_free_flag |-> !o_scl_oe)
    else $error("bus free while clock held");
  pause_hold_a: assert property (o_master_pause_flag [*2] |-> o_scl_oe)
    else $error("pause without clock hold");
  start_flag_a:
    assert property ($rose(o_master_active_flag) |-> ##[1:3] o_start_detect_flag)
    else $error("no start flag");
  nack_irq_a:
    assert property ($rose(o_nack_detect_flag) && i_nack_irq_enable |-> ##[0:1] o_error_irq_flag)
    else $error("no error irq on nack");
  rx_flag_a: assert property ($rose(o_rx_valid) |-> ##[0:2] o_receive_flag)
    else $error("no receive flag");
  cnt_zero_a: assert property ($rose(o_count_done_flag) |-> o_byte_counter == 8'h00)
    else $error("count done with count left");
endmodule
bind i2cm_top i2cm_monitor i_mon (.*);

// ===== tb/i2cm_slave_model.sv
module i2cm_slave_model #(
  parameter logic [7:0] RD_BYTE = 8'ha5
) (
  input wire i_scl,
  input wire i_sda,
  input wire i_nack,
  output logic o_sda_oe = 1'b0,
  output logic o_scl_oe = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  logic [7:0] sh = 8'h00;
  logic first = 1'b0, rd = 1'b0;
  // SDA edge with SCL high: Start, Restart or Stop
  always @(i_sda) begin
    // Settle first: SDA may move in the same step as SCL falls
    #1;
    if (i_scl === 1'b1) begin
      cnt = 0;
      first = !i_sda;
      rd = 1'b0;
    end
  end
  always @(posedge i_scl) begin
    if (cnt < 8) sh = {sh[6:0], i_sda};
    cnt = cnt + 1;
  end
  always @(negedge i_scl) begin
    if (cnt == 9) begin
      cnt = 0;
      rd = rd || (first && sh[0]);
      first = 1'b0;
    end
    // Open drain: only zeros are driven, so ones read back as the pull-up
    o_sda_oe = (cnt == 8 && !rd && !i_nack) || (rd && cnt < 8 && !RD_BYTE[7-cnt]);
    if (cnt == 0 && !rd) begin
      o_scl_oe = 1'b1;
      #64;
      o_scl_oe = 1'b0;
    end
  end
endmodule

// ===== tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rows [3] = '{8'h01, 8'h02, 8'h04};
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, restart_enable = 1'b0, bad = 1'b0, rdy = 1'b1, ld = 1'b0;
  logic [7:0] cnt_v = 8'h00;
  logic [10:0] clr = 11'h000;
  logic [2:0] mode = 3'h5;
  logic [7:0] adh = 8'hf0, adl = 8'h5a, txd = 8'h00;
  logic [6:0] own = 7'h3c;
  logic [4:0] ien = 5'h1f;
  logic abd = 1'b0, txw = 1'b0, ack_data_value = 1'b0, end_of_count_ack = 1'b1, sclr = 1'b0;
  // Addressable as a slave in multi-master mode
  logic ahe = 1'b1, stretch_disable = 1'b0;
  int errors = 0, n_checks = 0, pops = 0, cyc = 0;
  wire m_scl, m_sda, s_scl, s_sda, rxv, full, pause, bfree, stopf, nackf, cdone, eirq, mact;
  wire [7:0] rxb, bcnt;
  wire scl = !(m_scl || s_scl);
  wire sda = !(m_sda || s_sda);
  always #2.5 clk = !clk;
  i2cm_slave_model i_i2cm_slave_model (.i_scl(scl), .i_sda(sda), .i_nack(bad), .o_sda_oe(s_sda),
    .o_scl_oe(s_scl));
  i2cm_top #(.LOW_CYC(16'h0008), .HIGH_CYC(16'h0008), .SU_CYC(16'h0008), .FREE_CYC(16'h0010))
  i_i2cm_top (.i_ref_clk(clk), .i_reset(rst), .i_scl(scl), .o_scl(), .o_scl_oe(m_scl),
    .i_sda(sda), .o_sda(), .o_sda_oe(m_sda), .i_mode(mode), .i_addr_buffer_disable(abd),
    .i_restart_enable(restart_enable), .i_start_set(start), .i_addr_high_buffer(adh),
    .i_addr_low_buffer(adl), .i_tx_write(txw), .i_transmit_buffer(txd), .i_cnt_load(ld),
    .i_cnt_value(cnt_v), .i_ack_data_value(ack_data_value), .i_end_of_count_ack(end_of_count_ack),
    .i_address_hold_enable(ahe), .i_stretch_disable(stretch_disable), .i_own_addr(own),
    .i_stretch_clear(sclr), .i_start_irq_enable(ien[0]), .i_restart_irq_enable(ien[1]),
    .i_receive_irq_enable(ien[2]), .i_nack_irq_enable(ien[3]), .i_collision_irq_enable(ien[4]),
    .i_flag_clear(clr), .i_rx_ready(rdy), .o_rx_valid(rxv), .o_receive_buffer(rxb),
    .o_rx_buffer_full(full), .o_tx_buffer_empty(), .o_byte_counter(bcnt),
    .o_master_pause_flag(pause), .o_master_active_flag(mact), .o_bus_free_flag(bfree),
    .o_slave_active_flag(), .o_slave_stretch_bit(), .o_start_detect_flag(),
    .o_restart_detect_flag(), .o_stop_detect_flag(stopf), .o_nack_detect_flag(nackf),
    .o_count_done_flag(cdone), .o_transmit_flag(), .o_receive_flag(), .o_collision_flag(),
    .o_address_match_flag(), .o_general_irq_flag(), .o_error_irq_flag(eirq));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic final_report;
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic go;
    @(posedge clk);
    start <= 1'b1;
    clr <= 11'h000;
    ld <= 1'b0;
    @(posedge clk);
    start <= 1'b0;
  endtask
  // Write-address phase, pause, then read n bytes after a Restart
  task automatic xact(input logic [7:0] n, input logic stall, input logic nk);
    // Start is only taken once the previous Stop has fully finished
    wait (bfree === 1'b1 && mact === 1'b0);
    @(posedge clk);
    clr <= 11'h7ff;
    restart_enable <= 1'b1;
    rdy <= !stall;
    bad <= nk;
    pops = 0;
    go();
    wait (pause === 1'b1);
    // Sticky flags trail the pause by one cycle
    repeat (2) @(negedge clk);
    chk1(nackf, nk);
    chk1(eirq, nk);
    @(posedge clk);
    restart_enable <= 1'b0;
    ld <= 1'b1;
    cnt_v <= n;
    go();
    if (stall) begin
      wait (pause === 1'b1 && full === 1'b1);
      chk1(rxv, 1'b1);
      @(posedge clk);
      rdy <= 1'b1;
    end
    wait (stopf === 1'b1);
    chk8(pops[7:0], n);
    chk1(cdone, !nk);
  endtask
  always @(negedge clk) begin
    if (!rst && rxv === 1'b1 && rdy === 1'b1) begin
      chk8(rxb, 8'ha5);
      pops++;
    end
  end
  // Five transfers of at most four bytes each fit well inside this ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk1(bfree, 1'b0);
    foreach (rows[i]) begin
      xact(rows[i], 1'b0, 1'b0);
      chk8(bcnt, 8'h00);
    end
    xact(8'h03, 1'b1, 1'b0);
    xact(8'h00, 1'b0, 1'b1);
    final_report();
  end
endmodule
